// ==== logic/fbp_ctrl.sv ====
/*
  Host controller for the block-protection command sets of a two-die NOR flash.
  Assumes an Avalon-MM master on the register side and the flash pins on the other;
  the flash reset pin is driven from the same reset as this block.
*/
`timescale 1ns/100ps
module fbp_ctrl (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash bus.
  output logic [fbp_pkg::ADDR_W-1:0] flash_addr,
  output logic [fbp_pkg::DQ_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [fbp_pkg::DQ_W-1:0] flash_dq_in,
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic flash_rst_b,
  // Write-protect pin levels.
  output logic wp_high,
  output logic high_program_level
);
  typedef enum logic [1:0] {
    M_IDLE = 2'h0, M_RUN = 2'h1, M_WAIT = 2'h2
  } fbp_mstate_t;

  typedef struct packed {
    fbp_mstate_t st;
    logic [1:0] idx;
    fbp_pkg::fbp_op_t op;
    logic [fbp_pkg::ADDR_W-1:0] addr;
    fbp_pkg::fbp_mode_t [1:0] mode;
    logic busy;
    logic refused;
    logic prot;
    logic polling;
    logic poll_armed;
    logic poll_prev;
    logic [fbp_pkg::DQ_W-1:0] rdata;
    logic wp;
    logic hpl_req;
    logic hpl;
    logic rst_out;
    logic wait_n;
    logic [31:0] rd_word;
    logic cyc_start;
    logic cyc_rd;
    logic [fbp_pkg::ADDR_W-1:0] cyc_addr;
    logic [fbp_pkg::DQ_W-1:0] cyc_data;
  } fbp_ctrl_state_t;

  fbp_ctrl_state_t s;
  fbp_ctrl_state_t next_s;
  logic cyc_done;
  logic [fbp_pkg::DQ_W-1:0] cyc_rdata;

  // Bus cycles of each operation; every address carries the die select bit.
  function automatic fbp_pkg::fbp_step_t step_of(input fbp_pkg::fbp_op_t op,
      input logic [1:0] idx, input logic [fbp_pkg::ADDR_W-1:0] a);
    logic [fbp_pkg::ADDR_W-1:0] die;
    logic [fbp_pkg::DQ_W-1:0] code;
    fbp_pkg::fbp_step_t r;
    die = '0;
    die[fbp_pkg::DIE_BIT] = a[fbp_pkg::DIE_BIT];
    code = fbp_pkg::CODE_ENTER_NV;
    r = '{last: 1'b1, rd: 1'b0, addr: die, data: fbp_pkg::CODE_EXIT2};
    case (op)
      fbp_pkg::OP_ENTER_NV, fbp_pkg::OP_ENTER_LOCK, fbp_pkg::OP_ENTER_VOL,
      fbp_pkg::OP_ENTER_EXT, fbp_pkg::OP_EXIT_EXT: begin
        if (op == fbp_pkg::OP_ENTER_LOCK) code = fbp_pkg::CODE_ENTER_LOCK;
        if (op == fbp_pkg::OP_ENTER_VOL) code = fbp_pkg::CODE_ENTER_VOL;
        if (op == fbp_pkg::OP_ENTER_EXT) code = fbp_pkg::CODE_ENTER_EXT;
        if (op == fbp_pkg::OP_EXIT_EXT) code = fbp_pkg::CODE_EXIT1;
        case (idx)
          2'h0: r = '{1'b0, 1'b0, die | fbp_pkg::ADDR_UNLK1, fbp_pkg::CODE_UNLK1};
          2'h1: r = '{1'b0, 1'b0, die | fbp_pkg::ADDR_UNLK2, fbp_pkg::CODE_UNLK2};
          2'h2: r = '{op != fbp_pkg::OP_EXIT_EXT, 1'b0, die | fbp_pkg::ADDR_UNLK1, code};
          default: r = '{1'b1, 1'b0, die, fbp_pkg::CODE_EXIT2};
        endcase
      end
      fbp_pkg::OP_PROG_NV, fbp_pkg::OP_PROG_VOL, fbp_pkg::OP_CLEAR_VOL: begin
        if (idx == 2'h0) begin
          r = '{1'b0, 1'b0, die, fbp_pkg::CODE_PROG};
        end else if (op == fbp_pkg::OP_CLEAR_VOL) begin
          r = '{1'b1, 1'b0, a, fbp_pkg::DATA_CLEAR};
        end else begin
          r = '{1'b1, 1'b0, a, fbp_pkg::DATA_SET};
        end
      end
      fbp_pkg::OP_PROG_LOCK: begin
        r = '{idx != 2'h0, 1'b0, die, idx == 2'h0 ? fbp_pkg::CODE_PROG
                                                  : fbp_pkg::DATA_SET};
      end
      fbp_pkg::OP_CLEAR_NV: begin
        r = '{idx != 2'h0, 1'b0, die, idx == 2'h0 ? fbp_pkg::CODE_CLR1
                                                  : fbp_pkg::CODE_CLR2};
      end
      fbp_pkg::OP_READ_NV, fbp_pkg::OP_READ_VOL, fbp_pkg::OP_READ_WORD: begin
        r = '{1'b1, 1'b1, a, '0};
      end
      fbp_pkg::OP_READ_LOCK: begin
        r = '{1'b1, 1'b1, die, '0};
      end
      fbp_pkg::OP_EXIT_PROT: begin
        r = '{idx != 2'h0, 1'b0, die, idx == 2'h0 ? fbp_pkg::CODE_EXIT1
                                                  : fbp_pkg::CODE_EXIT2};
      end
      default: r = '{1'b1, 1'b1, a, '0};
    endcase
    return r;
  endfunction : step_of

  // An operation is accepted only in the command set that it belongs to; a word read is accepted in any mode.
  function automatic logic legal(input fbp_pkg::fbp_op_t op,
      input fbp_pkg::fbp_mode_t m, input logic hpl);
    logic ok;
    case (op)
      fbp_pkg::OP_ENTER_NV, fbp_pkg::OP_ENTER_LOCK, fbp_pkg::OP_ENTER_VOL,
      fbp_pkg::OP_ENTER_EXT: ok = (m == fbp_pkg::MODE_READ) && !hpl;
      fbp_pkg::OP_PROG_NV, fbp_pkg::OP_READ_NV,
      fbp_pkg::OP_CLEAR_NV: ok = (m == fbp_pkg::MODE_NV);
      fbp_pkg::OP_PROG_LOCK, fbp_pkg::OP_READ_LOCK: ok = (m == fbp_pkg::MODE_LOCK);
      fbp_pkg::OP_PROG_VOL, fbp_pkg::OP_CLEAR_VOL,
      fbp_pkg::OP_READ_VOL: ok = (m == fbp_pkg::MODE_VOL);
      fbp_pkg::OP_EXIT_EXT: ok = (m == fbp_pkg::MODE_EXT);
      fbp_pkg::OP_EXIT_PROT: ok = (m == fbp_pkg::MODE_NV) || (m == fbp_pkg::MODE_LOCK)
                                  || (m == fbp_pkg::MODE_VOL);
      fbp_pkg::OP_READ_WORD: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : legal

  always_comb begin
    fbp_pkg::fbp_step_t stp;
    fbp_pkg::fbp_op_t new_op;
    logic die;
    logic both_read;
    stp = step_of(s.op, s.idx, s.addr);
    new_op = fbp_pkg::fbp_op_t'(avs_writedata[3:0]);
    die = s.addr[fbp_pkg::DIE_BIT];
    both_read = (s.mode[0] == fbp_pkg::MODE_READ) && (s.mode[1] == fbp_pkg::MODE_READ);
    next_s = s;
    next_s.cyc_start = 1'b0;
    next_s.wait_n = 1'b1;
    next_s.rst_out = 1'b1;
    // Each request is answered one cycle after it is seen, then released.
    if ((avs_read || avs_write) && s.wait_n) begin
      next_s.wait_n = 1'b0;
      next_s.rd_word = 32'h00000000;
      if (avs_write) begin
        case (avs_address)
          fbp_pkg::REG_CTRL: begin
            if (s.busy || !legal(new_op, s.mode[die], s.hpl)) begin
              next_s.refused = 1'b1;
            end else begin
              next_s.op = new_op;
              next_s.refused = 1'b0;
              next_s.busy = 1'b1;
              next_s.idx = 2'h0;
              next_s.polling = 1'b0;
              next_s.st = M_RUN;
            end
          end
          fbp_pkg::REG_ADDR: begin
            if (!s.busy) next_s.addr = avs_writedata[fbp_pkg::ADDR_W-1:0];
          end
          fbp_pkg::REG_PINS: begin
            next_s.wp = avs_writedata[fbp_pkg::PINS_WP_BIT];
            next_s.hpl_req = avs_writedata[fbp_pkg::PINS_HPL_BIT];
          end
          default: begin
          end
        endcase
      end else begin
        case (avs_address)
          fbp_pkg::REG_CTRL: next_s.rd_word = {28'h0000000, s.op};
          fbp_pkg::REG_ADDR: next_s.rd_word = {7'h00, s.addr};
          fbp_pkg::REG_PINS: next_s.rd_word = {29'h00000000, s.hpl, s.hpl_req, s.wp};
          fbp_pkg::REG_STAT: next_s.rd_word = {22'h000000, s.mode[1], s.mode[0],
                                               1'b0, s.prot, s.refused, s.busy};
          fbp_pkg::REG_RDATA: next_s.rd_word = {16'h0000, s.rdata};
          default: next_s.rd_word = 32'h00000000;
        endcase
      end
    end
    // The high programming level is only raised while both dies sit in read mode.
    next_s.hpl = s.hpl_req && (s.hpl || (both_read && !s.busy));
    case (s.st)
      M_IDLE: begin
      end
      M_RUN: begin
        next_s.cyc_start = 1'b1;
        next_s.cyc_rd = s.polling ? 1'b1 : stp.rd;
        next_s.cyc_addr = s.polling ? s.addr : stp.addr;
        next_s.cyc_data = stp.data;
        next_s.st = M_WAIT;
      end
      M_WAIT: begin
        if (cyc_done) begin
          next_s.st = M_RUN;
          if (s.polling) begin
            // Programming is over once the toggle bit stops changing.
            next_s.poll_armed = 1'b1;
            next_s.poll_prev = cyc_rdata[fbp_pkg::TOGGLE_BIT];
            if (s.poll_armed && (cyc_rdata[fbp_pkg::TOGGLE_BIT] == s.poll_prev)) begin
              next_s.st = M_IDLE;
              next_s.busy = 1'b0;
            end
          end else if (!stp.last) begin
            next_s.idx = s.idx + 2'h1;
          end else if (s.op == fbp_pkg::OP_PROG_NV || s.op == fbp_pkg::OP_CLEAR_NV
                       || s.op == fbp_pkg::OP_PROG_LOCK || s.op == fbp_pkg::OP_PROG_VOL
                       || s.op == fbp_pkg::OP_CLEAR_VOL) begin
            next_s.polling = 1'b1;
            next_s.poll_armed = 1'b0;
          end else begin
            next_s.st = M_IDLE;
            next_s.busy = 1'b0;
            if (stp.rd) begin
              next_s.rdata = cyc_rdata;
              next_s.prot = cyc_rdata[fbp_pkg::PROT_BIT];
            end
            case (s.op)
              fbp_pkg::OP_ENTER_NV: next_s.mode[die] = fbp_pkg::MODE_NV;
              fbp_pkg::OP_ENTER_LOCK: next_s.mode[die] = fbp_pkg::MODE_LOCK;
              fbp_pkg::OP_ENTER_VOL: next_s.mode[die] = fbp_pkg::MODE_VOL;
              fbp_pkg::OP_ENTER_EXT: next_s.mode[die] = fbp_pkg::MODE_EXT;
              fbp_pkg::OP_EXIT_EXT,
              fbp_pkg::OP_EXIT_PROT: next_s.mode[die] = fbp_pkg::MODE_READ;
              default: begin
              end
            endcase
          end
        end
      end
      default: begin
        next_s.st = M_IDLE;
      end
    endcase
  end

  // Flash reset follows this reset, so both die modes restart in read mode.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{st: M_IDLE, idx: 2'h0, op: fbp_pkg::OP_READ_WORD, addr: '0,
             mode: '{fbp_pkg::MODE_READ, fbp_pkg::MODE_READ}, busy: 1'b0, refused: 1'b0,
             prot: 1'b0, polling: 1'b0, poll_armed: 1'b0, poll_prev: 1'b0, rdata: '0,
             wp: fbp_pkg::PINS_WP_RESET, hpl_req: 1'b0, hpl: 1'b0, rst_out: 1'b0,
             wait_n: 1'b1, rd_word: 32'h00000000, cyc_start: 1'b0, cyc_rd: 1'b0,
             cyc_addr: '0, cyc_data: '0};
    end else begin
      s <= next_s;
    end
  end

  fbp_bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(s.cyc_start),
    .rd(s.cyc_rd),
    .addr(s.cyc_addr),
    .wdata(s.cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pin_addr(flash_addr),
    .pin_dq_out(flash_dq_out),
    .pin_dq_oe(flash_dq_oe),
    .pin_dq_in(flash_dq_in),
    .pin_ce_b(flash_ce_b),
    .pin_oe_b(flash_oe_b),
    .pin_we_b(flash_we_b)
  );

  assign avs_readdata = s.rd_word;
  assign avs_waitrequest = s.wait_n;
  assign flash_rst_b = s.rst_out;
  assign wp_high = s.wp;
  assign high_program_level = s.hpl;

  wait_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low two cycles");
  nv_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s.wait_n && avs_write && avs_address == fbp_pkg::REG_CTRL && !s.busy
     && avs_writedata[3:0] == 4'h1 && s.mode[s.addr[24]] != fbp_pkg::MODE_NV)
    |=> s.refused && !s.busy) else $error("nonvolatile op taken outside its set");
  hpl_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(high_program_level) |-> $past(s.mode[0]) == fbp_pkg::MODE_READ
    && $past(s.mode[1]) == fbp_pkg::MODE_READ && !$past(s.busy))
    else $error("high program level raised outside read mode");
  enter_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s.st == M_WAIT && cyc_done && s.op == fbp_pkg::OP_ENTER_VOL && s.idx == 2'h2)
    |=> s.mode[s.addr[24]] == fbp_pkg::MODE_VOL && !s.busy)
    else $error("volatile set not entered");
  cov_poll_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    s.polling && cyc_done ##[1:100] !s.busy);
  cov_refuse_c: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(s.refused));
  cov_ext_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    s.mode[1] == fbp_pkg::MODE_EXT);
endmodule : fbp_ctrl

// ==== shared/fbp_pkg.sv ====
/*
  Constants and types shared by the flash block-protection controller.
  Assumes a x16 parallel NOR bus with word addresses and a 100 MHz clock.
*/
package fbp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ACCESS_NS = 90;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_NS = 30;
  localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 2;
  localparam int ADDR_W = 25;
  localparam int DQ_W = 16;
  localparam int DIE_BIT = 24;
  localparam int TOGGLE_BIT = 6;
  localparam int PROT_BIT = 0;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_PINS = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int PINS_WP_BIT = 0;
  localparam int PINS_HPL_BIT = 1;
  localparam logic PINS_WP_RESET = 1'h1;
  // Bus command codes.
  localparam logic [ADDR_W-1:0] ADDR_UNLK1 = 25'h0000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLK2 = 25'h00002aa;
  localparam logic [DQ_W-1:0] CODE_UNLK1 = 16'h00aa;
  localparam logic [DQ_W-1:0] CODE_UNLK2 = 16'h0055;
  localparam logic [DQ_W-1:0] CODE_ENTER_NV = 16'h00c0;
  localparam logic [DQ_W-1:0] CODE_ENTER_LOCK = 16'h0050;
  localparam logic [DQ_W-1:0] CODE_ENTER_VOL = 16'h00e0;
  localparam logic [DQ_W-1:0] CODE_ENTER_EXT = 16'h0088;
  localparam logic [DQ_W-1:0] CODE_PROG = 16'h00a0;
  localparam logic [DQ_W-1:0] CODE_CLR1 = 16'h0080;
  localparam logic [DQ_W-1:0] CODE_CLR2 = 16'h0030;
  localparam logic [DQ_W-1:0] CODE_EXIT1 = 16'h0090;
  localparam logic [DQ_W-1:0] CODE_EXIT2 = 16'h0000;
  localparam logic [DQ_W-1:0] DATA_SET = 16'h0000;
  localparam logic [DQ_W-1:0] DATA_CLEAR = 16'h0001;

  typedef enum logic [3:0] {
    OP_ENTER_NV = 4'h0, OP_PROG_NV = 4'h1, OP_READ_NV = 4'h2, OP_CLEAR_NV = 4'h3,
    OP_ENTER_LOCK = 4'h4, OP_PROG_LOCK = 4'h5, OP_READ_LOCK = 4'h6,
    OP_ENTER_VOL = 4'h7, OP_PROG_VOL = 4'h8, OP_CLEAR_VOL = 4'h9, OP_READ_VOL = 4'ha,
    OP_ENTER_EXT = 4'hb, OP_EXIT_EXT = 4'hc, OP_EXIT_PROT = 4'hd, OP_READ_WORD = 4'he
  } fbp_op_t;

  typedef enum logic [2:0] {
    MODE_READ = 3'h0, MODE_NV = 3'h1, MODE_LOCK = 3'h2, MODE_VOL = 3'h3, MODE_EXT = 3'h4
  } fbp_mode_t;

  typedef struct packed {
    logic last;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] data;
  } fbp_step_t;
endpackage : fbp_pkg

// ==== logic/fbp_bus_cycle.sv ====
/*
  One asynchronous flash bus cycle, write or read, with fixed pin timing.
  Assumes start pulses only while idle; dq_in arrives unsynchronised from the pin.
*/
`timescale 1ns/100ps
module fbp_bus_cycle (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Request and answer.
  input wire logic start,
  input wire logic rd,
  input wire logic [fbp_pkg::ADDR_W-1:0] addr,
  input wire logic [fbp_pkg::DQ_W-1:0] wdata,
  output logic done,
  output logic [fbp_pkg::DQ_W-1:0] rdata,
  // Flash pins.
  output logic [fbp_pkg::ADDR_W-1:0] pin_addr,
  output logic [fbp_pkg::DQ_W-1:0] pin_dq_out,
  output logic pin_dq_oe,
  input wire logic [fbp_pkg::DQ_W-1:0] pin_dq_in,
  output logic pin_ce_b,
  output logic pin_oe_b,
  output logic pin_we_b
);
  typedef enum logic [1:0] {
    C_IDLE = 2'h0, C_SETUP = 2'h1, C_ACT = 2'h2, C_HOLD = 2'h3
  } fbp_cyc_t;

  typedef struct packed {
    fbp_cyc_t st;
    logic [7:0] cnt;
    logic rd;
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic dq_oe;
    logic done;
    logic [fbp_pkg::ADDR_W-1:0] a;
    logic [fbp_pkg::DQ_W-1:0] dout;
    logic [fbp_pkg::DQ_W-1:0] din;
    logic [fbp_pkg::DQ_W-1:0] sync1;
    logic [fbp_pkg::DQ_W-1:0] sync2;
  } fbp_cyc_state_t;

  fbp_cyc_state_t s;
  fbp_cyc_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sync1 = pin_dq_in;
    next_s.sync2 = s.sync1;
    case (s.st)
      C_IDLE: begin
        if (start) begin
          next_s.a = addr;
          next_s.dout = wdata;
          next_s.rd = rd;
          next_s.dq_oe = !rd;
          next_s.st = C_SETUP;
        end
      end
      C_SETUP: begin
        next_s.ce_b = 1'b0;
        next_s.oe_b = !s.rd;
        next_s.we_b = s.rd;
        // Reads wait out the input synchroniser on top of the access time.
        next_s.cnt = s.rd ? 8'(fbp_pkg::ACCESS_CYC + fbp_pkg::SYNC_CYC)
                          : 8'(fbp_pkg::ACCESS_CYC);
        next_s.st = C_ACT;
      end
      C_ACT: begin
        next_s.cnt = s.cnt - 8'h01;
        if (s.cnt == 8'h01) begin
          if (s.rd) begin
            next_s.din = s.sync2;
          end
          next_s.ce_b = 1'b1;
          next_s.oe_b = 1'b1;
          next_s.we_b = 1'b1;
          next_s.cnt = 8'(fbp_pkg::RECOVER_CYC);
          next_s.st = C_HOLD;
        end
      end
      C_HOLD: begin
        next_s.cnt = s.cnt - 8'h01;
        if (s.cnt == 8'h01) begin
          next_s.dq_oe = 1'b0;
          next_s.done = 1'b1;
          next_s.st = C_IDLE;
        end
      end
      default: begin
        next_s.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{st: C_IDLE, cnt: 8'h00, rd: 1'b0, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1,
             dq_oe: 1'b0, done: 1'b0, a: '0, dout: '0, din: '0, sync1: '0, sync2: '0};
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign rdata = s.din;
  assign pin_addr = s.a;
  assign pin_dq_out = s.dout;
  assign pin_dq_oe = s.dq_oe;
  assign pin_ce_b = s.ce_b;
  assign pin_oe_b = s.oe_b;
  assign pin_we_b = s.we_b;

  rw_exclusive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(!s.oe_b && !s.we_b)) else $error("output and write enables low together");
  bus_contention_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !s.oe_b |-> !s.dq_oe) else $error("host drives dq during a read");
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s.done |=> !s.done) else $error("done held longer than one cycle");
  we_width_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(s.we_b) |-> !s.we_b[*8] ##1 !s.we_b ##1 s.we_b) else $error("write pulse width wrong");
endmodule : fbp_bus_cycle

// ==== sim/fbp_flash_model.sv ====
/* Behavioural two-die flash that answers the protection command sets in x16 words.
   Assumes the controller's bus cycles; dq shows inverted data while oe_b or ce_b is high. */
`timescale 1ns/100ps
module fbp_flash_model (
  // Flash bus.
  input wire logic [24:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in,
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic rst_b
);
  logic nv [2][256];
  logic vol [2][256];
  logic frz [2];
  logic [2:0] md [2];
  logic [1:0] cy [2];
  logic [1:0] pd [2];
  logic [1:0] p, k;
  logic d;
  logic [7:0] b, c;
  logic [15:0] rv = 16'h0;
  int tg = 0;
  initial foreach (nv[i, j]) nv[i][j] = 1'b1;
  always @(posedge we_b or negedge rst_b) begin
    if (!rst_b) begin
      foreach (vol[i, j]) vol[i][j] = 1'b1;
      frz = '{1'b0, 1'b0};
      md = '{3'h0, 3'h0};
      cy = '{2'h0, 2'h0};
      pd = '{2'h0, 2'h0};
    end else if (dq_oe) begin
      // Chip enable rises together with the write strobe, so the data enable marks a write.
      d = addr[24];
      b = addr[23:16];
      c = dq_out[7:0];
      p = pd[d];
      k = cy[d];
      pd[d] = 2'h0;
      cy[d] = 2'h0;
      if (p == 2'h1) begin
        if (md[d] == 3'h1 && !frz[d]) nv[d][b] = 1'b0;
        if (md[d] == 3'h3) vol[d][b] = dq_out[0];
        if (md[d] == 3'h2) frz[d] = 1'b1;
        tg = 3;
      end else if (p == 2'h2 && c == 8'h30) begin
        if (!frz[d]) for (int j = 0; j < 256; j++) nv[d][j] = 1'b1;
        tg = 3;
      end else if (p == 2'h3 && c == 8'h00) md[d] = 3'h0;
      else if (k == 2'h2 && c != 8'h90) begin
        md[d] = c == 8'hc0 ? 3'h1 : c == 8'h50 ? 3'h2 : c == 8'he0 ? 3'h3 : 3'h4;
      end else if (c == 8'haa) cy[d] = 2'h1;
      else if (k == 2'h1 && c == 8'h55) cy[d] = 2'h2;
      else pd[d] = c == 8'ha0 ? 2'h1 : c == 8'h80 ? 2'h2 : c == 8'h90 ? 2'h3 : 2'h0;
    end
  end
  // After a program or clear, bit 6 toggles on each of the next three reads of either die.
  always @(negedge oe_b) begin
    case (md[addr[24]])
      3'h1: rv = {15'h0, nv[addr[24]][addr[23:16]]};
      3'h2: rv = {15'h0, !frz[addr[24]]};
      3'h3: rv = {15'h0, vol[addr[24]][addr[23:16]]};
      default: rv = addr[15:0];
    endcase
    if (tg > 0) begin
      tg--;
      rv[6] = tg[0];
    end
  end
  assign dq_in = (oe_b || ce_b) ? ~rv : rv;
endmodule : fbp_flash_model

// ==== sim/fbp_ctrl_tb_top.sv ====
/* Self-checking bench for the block-protection controller over Avalon-MM.
   Assumes the behavioural flash model on the flash pins. */
`timescale 1ns/100ps
module fbp_ctrl_tb_top;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, dq_oe, ce_b, oe_b, we_b, f_rst_b;
  logic wp_high, high_program_level;
  logic [7:0] avs_address, b;
  logic [31:0] avs_writedata, avs_readdata, rdat, st, a;
  logic [24:0] f_addr;
  logic [15:0] dq_o, dq_i;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'hd0da;
  fbp_ctrl fbp_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(f_addr),
    .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i), .flash_ce_b(ce_b),
    .flash_oe_b(oe_b), .flash_we_b(we_b), .flash_rst_b(f_rst_b), .wp_high(wp_high),
    .high_program_level(high_program_level));
  fbp_flash_model fbp_flash_model_inst (.addr(f_addr), .dq_out(dq_o), .dq_in(dq_i),
    .dq_oe(dq_oe), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .rst_b(f_rst_b));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task results;
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  function automatic logic [31:0] blk(input logic di, input logic [7:0] bi);
    return {7'h0, di, bi, 16'h0};
  endfunction : blk
  // Runs one operation, waits for busy to drop and checks the refusal flag.
  task op(input logic [3:0] c, input logic [31:0] ad, input logic rf);
    bus(1'b1, 8'h04, ad);
    bus(1'b1, 8'h00, {28'h0, c});
    st = 32'h1;
    while (st[0] === 1'b1) begin
      bus(1'b0, 8'h0c, 32'h0);
      st = rdat;
    end
    chk("refused", {31'h0, rf}, {31'h0, st[1]});
  endtask : op
  task sts(input logic [3:0] c, input logic [31:0] ad, input logic [31:0] e);
    op(c, ad, 1'b0);
    chk("prot", e, st & 32'h4);
  endtask : sts
  initial begin
    rst_b = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(1'b0, 8'h08, 32'h0);
    chk("pins", 32'h1, rdat & 32'h7);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rdat);
    op(4'h1, 32'h0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      a = blk(i[0], b);
      op(4'h0, a, 1'b0);
      chk("mode", 32'h10 << (3 * i), st & 32'h3f0);
      sts(4'h2, a, 32'h4);
      op(4'h1, a, 1'b0);
      sts(4'h2, a, 32'h0);
      sts(4'h2, a ^ 32'h10000, 32'h4);
      op(4'h3, a, 1'b0);
      sts(4'h2, a, 32'h4);
      op(4'h1, a, 1'b0);
      op(4'hd, a, 1'b0);
      chk("mode", 32'h0, st & 32'h3f0);
      op(4'h4, a, 1'b0);
      sts(4'h6, a, 32'h4);
      op(4'h5, a, 1'b0);
      sts(4'h6, a, 32'h0);
      op(4'hd, a, 1'b0);
      op(4'h0, a, 1'b0);
      op(4'h3, a, 1'b0);
      sts(4'h2, a, 32'h0);
      op(4'hd, a, 1'b0);
      op(4'h7, a, 1'b0);
      op(4'h1, a, 1'b1);
      op(4'h8, a, 1'b0);
      sts(4'ha, a, 32'h0);
      sts(4'ha, a ^ 32'h10000, 32'h4);
      op(4'h9, a, 1'b0);
      sts(4'ha, a, 32'h4);
      op(4'hd, a, 1'b0);
    end
    op(4'hb, 32'h0, 1'b0);
    chk("mode", 32'h40, st & 32'h3f0);
    op(4'he, 32'h12, 1'b0);
    bus(1'b0, 8'h10, 32'h0);
    chk("rdata", 32'h12, rdat);
    op(4'h3, 32'h0, 1'b1);
    op(4'hc, 32'h0, 1'b0);
    chk("mode", 32'h0, st & 32'h3f0);
    bus(1'b1, 8'h08, 32'h3);
    op(4'h0, 32'h0, 1'b1);
    chk("hpl", 32'h1, {31'h0, high_program_level});
    bus(1'b1, 8'h08, 32'h0);
    chk("wp", 32'h0, {31'h0, wp_high});
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    op(4'h4, a, 1'b0);
    sts(4'h6, a, 32'h4);
    op(4'hd, a, 1'b0);
    op(4'h0, a, 1'b0);
    sts(4'h2, a, 32'h0);
    op(4'hd, a, 1'b0);
    results();
  end
endmodule : fbp_ctrl_tb_top
